// File: src/exec_pkg.sv
/*
  Shared constants and carrier types for the integer add, logic and branch
  execute block. Assumes a 32-bit core with one branch delay slot.
*/
// Functional notes
// RL1 - Control-unit registers only via coprocessor moves
// RL2 - Trapping register add: overflow traps, no write
// RL3 - Trapping immediate add: sign-extend, overflow traps
// RL4 - Wrapping immediate add: sign-extend, never traps
// RL5 - Wrapping register add writes sum always
// RL6 - Register AND writes conjunction to destination
// RL7 - Immediate AND zero-extends, upper half zero
// RL8 - Target is delay-slot address plus offset*4
// RL9 - Equal branch taken when sources match
// RL10 - Nonneg branch taken when sign clear
// RL11 - Nonneg link branch always writes register 31
// RL12 - Positive branch: sign clear and nonzero
// RL13 - Nonpositive branch: sign set or zero
// RL14 - Negative branch taken when sign set
// RL15 - Negative link branch always writes register 31
// RL16 - Software avoids register 31 as linking source
// RL17 - Register zero never written
// RL18 - No branch inside a delay slot
// RL19 - Fixed instruction field positions
package exec_pkg;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int OP_HI = 31;
  localparam int OP_LO = 26;
  localparam int RS_HI = 25;
  localparam int RS_LO = 21;
  localparam int RT_HI = 20;
  localparam int RT_LO = 16;
  localparam int RD_HI = 15;
  localparam int RD_LO = 11;
  localparam int FN_HI = 5;
  localparam int FN_LO = 0;
  localparam int IMM_HI = 15;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] OP_SIGN_TEST_GROUP = 6'h01;
  localparam logic [5:0] OP_BRANCH_IF_EQUAL = 6'h04;
  localparam logic [5:0] OP_BRANCH_NONPOSITIVE = 6'h06;
  localparam logic [5:0] OP_BRANCH_POSITIVE = 6'h07;
  localparam logic [5:0] OP_ADD_IMM_TRAPPING = 6'h08;
  localparam logic [5:0] OP_ADD_IMM_WRAPPING = 6'h09;
  localparam logic [5:0] OP_BITWISE_CONJ_IMM = 6'h0c;
  localparam logic [5:0] FN_ADD_TRAPPING = 6'h20;
  localparam logic [5:0] FN_ADD_WRAPPING = 6'h21;
  localparam logic [5:0] FN_BITWISE_CONJ_REG = 6'h24;
  localparam logic [4:0] RT_BRANCH_NEGATIVE = 5'h00;
  localparam logic [4:0] RT_BRANCH_NONNEG = 5'h01;
  localparam logic [4:0] RT_BRANCH_NEGATIVE_LINK = 5'h10;
  localparam logic [4:0] RT_BRANCH_NONNEG_LINK = 5'h11;
  localparam logic [4:0] LINK_REG = 5'h1f;
  localparam logic [4:0] ZERO_REG = 5'h00;
  localparam logic [31:0] INSN_STEP = 32'h0000_0004;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [31:0] insn;
    logic [31:0] pc;
    logic [31:0] rs_val;
    logic [31:0] rt_val;
  } issue_t;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [31:0] data;
  } wb_t;

  typedef struct packed {
    logic redirect;
    logic [31:0] target;
  } pc_ctl_t;

endpackage

// File: src/add_ovf.sv
/*
  Wrapping 32-bit adder with signed overflow flag.
  Assumes purely combinational use inside the execute stage.
*/
`timescale 1ns/10ps
module add_ovf
  import exec_pkg::*;
(
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  output logic [31:0] sum_o,
  output logic ovf_o
);

  logic [31:0] low_sum;
  logic c30;
  logic c31;

  // ----------------------------------------------------------------
  // Carry comparison
  // ----------------------------------------------------------------
  // Carry out of bit 30 vs carry out of bit 31
  always_comb begin
    low_sum = {1'b0, a_i[30:0]} + {1'b0, b_i[30:0]};
    c30 = low_sum[31];
    c31 = (a_i[31] & b_i[31]) | (c30 & (a_i[31] ^ b_i[31]));
    sum_o = a_i + b_i;
    ovf_o = c30 ^ c31; // [RL2]
  end

endmodule

// File: src/int_exec.sv
/*
  Execute stage for add, AND and compare-and-branch instructions.
  Assumes the issue carrier is registered on mclk_i by the core and that
  register operands are already read; register file owns register zero too.
*/
`timescale 1ns/10ps
module int_exec
  import exec_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire issue_t issue_i,
  output wb_t wb_o,
  output pc_ctl_t pc_ctl_o,
  output logic ovf_exc_o
);

  typedef struct packed {
    wb_t wb;
    pc_ctl_t pc_ctl;
    logic ovf;
    logic branch_pend;
    logic [31:0] branch_target;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [5:0] op;
  logic [5:0] fn;
  logic [4:0] rs_f;
  logic [4:0] rt_f;
  logic [4:0] rd_f;
  logic [31:0] imm_sx;
  logic [31:0] imm_zx;
  logic [31:0] add_b;
  logic [31:0] sum;
  logic ovf;
  logic [31:0] slot_pc;
  logic [31:0] target;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  // Fixed field positions of the instruction word
  always_comb begin
    op = issue_i.insn[OP_HI:OP_LO]; // [RL19]
    fn = issue_i.insn[FN_HI:FN_LO];
    rs_f = issue_i.insn[RS_HI:RS_LO];
    rt_f = issue_i.insn[RT_HI:RT_LO];
    rd_f = issue_i.insn[RD_HI:RD_LO];
    imm_sx = {{16{issue_i.insn[IMM_HI]}}, issue_i.insn[IMM_HI:0]}; // [RL3] [RL4]
    imm_zx = {16'h0000, issue_i.insn[IMM_HI:0]}; // [RL7]
    slot_pc = issue_i.pc + INSN_STEP;
    target = slot_pc + {imm_sx[29:0], 2'b00}; // [RL8]
    add_b = (op == OP_SPECIAL) ? issue_i.rt_val : imm_sx;
  end

  // One shared adder serves every add form
  add_ovf u_add (
    .a_i(issue_i.rs_val),
    .b_i(add_b),
    .sum_o(sum),
    .ovf_o(ovf)
  );

  // ----------------------------------------------------------------
  // Decode and execute
  // ----------------------------------------------------------------
  // Branch outcome is held one instruction so the slot still runs
  always_comb begin
    state_next = state_reg;
    state_next.wb = '0;
    state_next.ovf = 1'b0;
    state_next.pc_ctl = '0;
    if (issue_i.valid) begin
      // Pending taken branch redirects after its delay slot issues
      if (state_reg.branch_pend) begin
        state_next.pc_ctl.redirect = 1'b1; // [RL8]
        state_next.pc_ctl.target = state_reg.branch_target;
        state_next.branch_pend = 1'b0;
      end
      state_next.branch_target = target;
      case (op)
        OP_SPECIAL: begin
          state_next.wb.addr = rd_f;
          if (fn == FN_ADD_TRAPPING) begin
            state_next.wb.data = sum;
            state_next.wb.we = ~ovf; // [RL2]
            state_next.ovf = ovf; // [RL2]
          end else if (fn == FN_ADD_WRAPPING) begin
            state_next.wb.data = sum;
            state_next.wb.we = 1'b1; // [RL5]
          end else if (fn == FN_BITWISE_CONJ_REG) begin
            state_next.wb.data = issue_i.rs_val & issue_i.rt_val; // [RL6]
            state_next.wb.we = 1'b1;
          end
        end
        OP_ADD_IMM_TRAPPING: begin
          state_next.wb.addr = rt_f;
          state_next.wb.data = sum;
          state_next.wb.we = ~ovf; // [RL3]
          state_next.ovf = ovf; // [RL3]
        end
        OP_ADD_IMM_WRAPPING: begin
          state_next.wb.addr = rt_f;
          state_next.wb.data = sum;
          state_next.wb.we = 1'b1; // [RL4]
        end
        OP_BITWISE_CONJ_IMM: begin
          state_next.wb.addr = rt_f;
          state_next.wb.data = issue_i.rs_val & imm_zx; // [RL7]
          state_next.wb.we = 1'b1;
        end
        OP_BRANCH_IF_EQUAL: begin
          state_next.branch_pend = (issue_i.rs_val == issue_i.rt_val); // [RL9]
        end
        OP_BRANCH_POSITIVE: begin
          state_next.branch_pend = ~issue_i.rs_val[31] & (|issue_i.rs_val); // [RL12]
        end
        OP_BRANCH_NONPOSITIVE: begin
          state_next.branch_pend = issue_i.rs_val[31] | ~(|issue_i.rs_val); // [RL13]
        end
        OP_SIGN_TEST_GROUP: begin
          // Link is written whether or not the branch is taken
          if (rt_f == RT_BRANCH_NEGATIVE_LINK || rt_f == RT_BRANCH_NONNEG_LINK) begin
            state_next.wb.we = 1'b1; // [RL11] [RL15]
            state_next.wb.addr = LINK_REG;
            state_next.wb.data = slot_pc + INSN_STEP;
          end
          if (rt_f == RT_BRANCH_NEGATIVE || rt_f == RT_BRANCH_NEGATIVE_LINK) begin
            state_next.branch_pend = issue_i.rs_val[31]; // [RL14] [RL15]
          end else if (rt_f == RT_BRANCH_NONNEG || rt_f == RT_BRANCH_NONNEG_LINK) begin
            state_next.branch_pend = ~issue_i.rs_val[31]; // [RL10] [RL11]
          end
        end
        default: begin
          state_next.wb.we = 1'b0;
        end
      endcase
      // Register zero never takes a write
      if (state_next.wb.addr == ZERO_REG) begin
        state_next.wb.we = 1'b0; // [RL17]
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_o = state_reg.wb;
  assign pc_ctl_o = state_reg.pc_ctl;
  assign ovf_exc_o = state_reg.ovf;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Reference values from field positions alone, so a datapath slip shows
  logic [31:0] chk_sum;
  logic [31:0] chk_target;
  assign chk_sum = issue_i.rs_val + issue_i.rt_val;
  assign chk_target = issue_i.pc + INSN_STEP + {{14{issue_i.insn[IMM_HI]}}, issue_i.insn[IMM_HI:0], 2'b00};

  property p_trap_no_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ovf_exc_o |-> !wb_o.we;
  endproperty
  a_trap_no_write: assert property (p_trap_no_write) else $error("write during overflow trap"); // [RL2]

  property p_add_imm_trapping_trap;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (issue_i.valid && op == OP_ADD_IMM_TRAPPING && ovf) |=> ovf_exc_o;
  endproperty
  a_add_imm_trapping_trap: assert property (p_add_imm_trapping_trap) else $error("immediate add overflow missed"); // [RL3]

  property p_add_imm_wrapping_notrap;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (issue_i.valid && op == OP_ADD_IMM_WRAPPING) |=> !ovf_exc_o;
  endproperty
  a_add_imm_wrapping_notrap: assert property (p_add_imm_wrapping_notrap) else $error("wrapping immediate add trapped"); // [RL4]

  property p_add_wrapping_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (issue_i.valid && op == OP_SPECIAL && fn == FN_ADD_WRAPPING && rd_f != ZERO_REG)
      |=> (wb_o.we && wb_o.data == $past(chk_sum) && !ovf_exc_o);
  endproperty
  a_add_wrapping_write: assert property (p_add_wrapping_write) else $error("wrapping add result wrong"); // [RL5]

  property p_bitwise_conj_imm_upper;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (issue_i.valid && op == OP_BITWISE_CONJ_IMM) |=> (wb_o.data[31:16] == 16'h0000);
  endproperty
  a_bitwise_conj_imm_upper: assert property (p_bitwise_conj_imm_upper) else $error("immediate AND upper half nonzero"); // [RL7]

  property p_beq_delay;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (issue_i.valid && op == OP_BRANCH_IF_EQUAL && issue_i.rs_val == issue_i.rt_val)
      ##1 issue_i.valid |=> (pc_ctl_o.redirect && pc_ctl_o.target == $past(chk_target, 2));
  endproperty
  a_beq_delay: assert property (p_beq_delay) else $error("equal branch not redirected after slot"); // [RL9]

  property p_link_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (issue_i.valid && op == OP_SIGN_TEST_GROUP && rt_f == RT_BRANCH_NEGATIVE_LINK)
      |=> (wb_o.we && wb_o.addr == LINK_REG && wb_o.data == $past(issue_i.pc) + 32'h0000_0008);
  endproperty
  a_link_write: assert property (p_link_write) else $error("link register not written"); // [RL15]

  property p_zero_reg;
    @(posedge mclk_i) disable iff (!rst_n_i)
    wb_o.we |-> (wb_o.addr != ZERO_REG);
  endproperty
  a_zero_reg: assert property (p_zero_reg) else $error("write to register zero"); // [RL17]

  property p_branch_positive_zero;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (issue_i.valid && op == OP_BRANCH_POSITIVE && issue_i.rs_val == 32'h0000_0000)
      ##1 issue_i.valid |=> !pc_ctl_o.redirect;
  endproperty
  a_branch_positive_zero: assert property (p_branch_positive_zero) else $error("positive branch taken on zero"); // [RL12]

endmodule

// File: verification/reg_file_model.sv
/*
  Behavioural register file that feeds operands to the execute stage.
  Assumes writes arrive on the write-back carrier and commit on mclk_i.
*/
`timescale 1ns/10ps
module reg_file_model
  import exec_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [31:0] insn_i,
  input wire wb_t wb_i,
  output logic [31:0] rs_val_o,
  output logic [31:0] rt_val_o
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] regs [32];

  // Commit write-back; register zero ignores writes
  always @(posedge mclk_i) begin
    if (wb_i.we && wb_i.addr != ZERO_REG) begin
      regs[wb_i.addr] <= wb_i.data;
    end
  end

  // Operand reads by field, zero register pinned so a stray write never leaks
  assign rs_val_o = (insn_i[RS_HI:RS_LO] == ZERO_REG) ? 32'h0 : regs[insn_i[RS_HI:RS_LO]];
  assign rt_val_o = (insn_i[RT_HI:RT_LO] == ZERO_REG) ? 32'h0 : regs[insn_i[RT_HI:RT_LO]];
endmodule

// File: verification/integer_add_logic_branch_exec_tb.sv
/*
  Self-checking bench for the execute stage: adds, ANDs and branches.
  Assumes a register file model as operand source; no loads or stores issued.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module integer_add_logic_branch_exec_tb
  import exec_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic valid = 1'b0;
  logic [31:0] insn = 32'h0;
  logic [31:0] pc = 32'h0;
  logic [31:0] rs_val;
  logic [31:0] rt_val;
  wb_t wb;
  pc_ctl_t pcc;
  logic ovf;
  int n_fail = 0;
  int n_compared = 0;

  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  int_exec u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .issue_i({valid, insn, pc, rs_val, rt_val}),
    .wb_o(wb), .pc_ctl_o(pcc), .ovf_exc_o(ovf));
  reg_file_model u_rf (.mclk_i(mclk_i), .insn_i(insn), .wb_i(wb), .rs_val_o(rs_val), .rt_val_o(rt_val));

  function automatic logic [31:0] rty(logic [5:0] fn, logic [4:0] s, logic [4:0] t, logic [4:0] d);
    return {OP_SPECIAL, s, t, d, 5'h00, fn};
  endfunction
  function automatic logic [31:0] ity(logic [5:0] op, logic [4:0] s, logic [4:0] t, logic [15:0] im);
    return {op, s, t, im};
  endfunction

  // Issue one word at the next edge; taken at the one after
  task automatic put(logic [31:0] w, logic [31:0] a);
    @(posedge mclk_i);
    valid <= 1'b1;
    insn <= w;
    pc <= a;
  endtask

  localparam logic [31:0] BR_PC = 32'h0000_1000;

  // Issue one add or AND word; hand back write-back and overflow of the next edge
  task automatic run_alu(input logic [31:0] w, output wb_t got, output logic trap);
    put(w, 32'h0000_0100);
    @(posedge mclk_i);
    valid <= 1'b0;
    #1;
    got = wb;
    trap = ovf;
  endtask

  // Branch, then a plain slot word at once; link shows at c1, redirect at c2
  task automatic run_br(input logic [31:0] w, output wb_t lnk, output pc_ctl_t got);
    put(w, BR_PC);
    put(32'h0000_0000, BR_PC + INSN_STEP);  // Slot holds no branch
    #1;
    lnk = wb;
    @(posedge mclk_i);
    valid <= 1'b0;
    #1;
    got = pcc;
  endtask

  // Delay-slot address plus the sign-extended word offset
  function automatic logic [31:0] exp_target(logic [15:0] off);
    return BR_PC + INSN_STEP + {{14{off[15]}}, off, 2'b00};
  endfunction

  // Register add with and without overflow
  task automatic t_add_trapping;
    wb_t got;
    logic trap;
    run_alu(rty(FN_ADD_TRAPPING, 5'd1, 5'd2, 5'd6), got, trap);
    `CHK(got.we, 1'b0)
    `CHK(trap, 1'b1)
    run_alu(rty(FN_ADD_TRAPPING, 5'd2, 5'd3, 5'd7), got, trap);
    `CHK(got.we, 1'b1)
    `CHK(trap, 1'b0)
    `CHK(got.addr, 5'd7)
    `CHK(got.data, 32'hffff_0f10)
  endtask

  // Wrapping add keeps the overflowed sum; register zero drops it
  task automatic t_add_wrapping;
    wb_t got;
    logic trap;
    run_alu(rty(FN_ADD_WRAPPING, 5'd1, 5'd2, 5'd6), got, trap);
    `CHK(got.we, 1'b1)
    `CHK(trap, 1'b0)
    `CHK(got.addr, 5'd6)
    `CHK(got.data, 32'h8000_0000)
    run_alu(rty(FN_ADD_WRAPPING, 5'd1, 5'd2, 5'd0), got, trap);
    `CHK(got.we, 1'b0)
    `CHK(trap, 1'b0)
  endtask

  // Trapping immediate add, overflow and sign-extended negative operand
  task automatic t_add_imm_trapping;
    wb_t got;
    logic trap;
    run_alu(ity(OP_ADD_IMM_TRAPPING, 5'd1, 5'd8, 16'h0001), got, trap);
    `CHK(got.we, 1'b0)
    `CHK(trap, 1'b1)
    run_alu(ity(OP_ADD_IMM_TRAPPING, 5'd2, 5'd8, 16'hfffe), got, trap);
    `CHK(got.we, 1'b1)
    `CHK(trap, 1'b0)
    `CHK(got.addr, 5'd8)
    `CHK(got.data, 32'hffff_ffff)
  endtask

  // Wrapping immediate add never traps
  task automatic t_add_imm_wrapping;
    wb_t got;
    logic trap;
    run_alu(ity(OP_ADD_IMM_WRAPPING, 5'd1, 5'd8, 16'h0001), got, trap);
    `CHK(got.we, 1'b1)
    `CHK(trap, 1'b0)
    `CHK(got.addr, 5'd8)
    `CHK(got.data, 32'h8000_0000)
  endtask

  // Register and immediate AND; immediate one clears the upper half
  task automatic t_conj;
    wb_t got;
    logic trap;
    run_alu(rty(FN_BITWISE_CONJ_REG, 5'd3, 5'd1, 5'd9), got, trap);
    `CHK(got.we, 1'b1)
    `CHK(trap, 1'b0)
    `CHK(got.addr, 5'd9)
    `CHK(got.data, 32'h7fff_0f0f)
    run_alu(ity(OP_BITWISE_CONJ_IMM, 5'd3, 5'd10, 16'hf0ff), got, trap);
    `CHK(got.we, 1'b1)
    `CHK(trap, 1'b0)
    `CHK(got.addr, 5'd10)
    `CHK(got.data, 32'h0000_000f)
  endtask

  // Two words on consecutive edges; each result stands one cycle
  task automatic t_back_to_back;
    put(rty(FN_ADD_WRAPPING, 5'd2, 5'd2, 5'd11), 32'h0000_0200);
    put(rty(FN_BITWISE_CONJ_REG, 5'd3, 5'd4, 5'd12), 32'h0000_0204);
    #1;
    `CHK(wb.we, 1'b1)
    `CHK(wb.addr, 5'd11)
    `CHK(wb.data, 32'h0000_0002)
    @(posedge mclk_i);
    valid <= 1'b0;
    #1;
    `CHK(wb.we, 1'b1)
    `CHK(wb.addr, 5'd12)
    `CHK(wb.data, 32'h8000_0000)
  endtask

  // Equal branch, taken and not taken
  task automatic t_branch_equal;
    wb_t lnk;
    pc_ctl_t got;
    run_br(ity(OP_BRANCH_IF_EQUAL, 5'd1, 5'd1, 16'h0010), lnk, got);
    `CHK(lnk.we, 1'b0)
    `CHK(got.redirect, 1'b1)
    `CHK(got.target, exp_target(16'h0010))
    run_br(ity(OP_BRANCH_IF_EQUAL, 5'd1, 5'd2, 16'h0010), lnk, got);
    `CHK(lnk.we, 1'b0)
    `CHK(got.redirect, 1'b0)
  endtask

  // Sign-clear branch on zero and on a negative value
  task automatic t_branch_nonneg;
    wb_t lnk;
    pc_ctl_t got;
    run_br(ity(OP_SIGN_TEST_GROUP, 5'd5, RT_BRANCH_NONNEG, 16'h0020), lnk, got);
    `CHK(lnk.we, 1'b0)
    `CHK(got.redirect, 1'b1)
    `CHK(got.target, exp_target(16'h0020))
    run_br(ity(OP_SIGN_TEST_GROUP, 5'd4, RT_BRANCH_NONNEG, 16'h0020), lnk, got);
    `CHK(lnk.we, 1'b0)
    `CHK(got.redirect, 1'b0)
  endtask

  // Linking sign-clear branch writes the link either way
  task automatic t_branch_nonneg_link;
    wb_t lnk;
    pc_ctl_t got;
    run_br(ity(OP_SIGN_TEST_GROUP, 5'd4, RT_BRANCH_NONNEG_LINK, 16'h0004), lnk, got);
    `CHK(lnk.we, 1'b1)
    `CHK(lnk.addr, LINK_REG)
    `CHK(lnk.data, BR_PC + INSN_STEP + INSN_STEP)
    `CHK(got.redirect, 1'b0)
    run_br(ity(OP_SIGN_TEST_GROUP, 5'd2, RT_BRANCH_NONNEG_LINK, 16'h0004), lnk, got);
    `CHK(lnk.we, 1'b1)
    `CHK(lnk.addr, LINK_REG)
    `CHK(lnk.data, BR_PC + INSN_STEP + INSN_STEP)
    `CHK(got.redirect, 1'b1)
    `CHK(got.target, exp_target(16'h0004))
  endtask

  // Sign-set branch with a backward offset
  task automatic t_branch_negative;
    wb_t lnk;
    pc_ctl_t got;
    run_br(ity(OP_SIGN_TEST_GROUP, 5'd4, RT_BRANCH_NEGATIVE, 16'hfff0), lnk, got);
    `CHK(lnk.we, 1'b0)
    `CHK(got.redirect, 1'b1)
    `CHK(got.target, exp_target(16'hfff0))
    run_br(ity(OP_SIGN_TEST_GROUP, 5'd5, RT_BRANCH_NEGATIVE, 16'hfff0), lnk, got);
    `CHK(lnk.we, 1'b0)
    `CHK(got.redirect, 1'b0)
  endtask

  // Linking sign-set branch at the most negative offset
  task automatic t_branch_negative_link;
    wb_t lnk;
    pc_ctl_t got;
    run_br(ity(OP_SIGN_TEST_GROUP, 5'd4, RT_BRANCH_NEGATIVE_LINK, 16'h8000), lnk, got);
    `CHK(lnk.we, 1'b1)
    `CHK(lnk.addr, LINK_REG)
    `CHK(lnk.data, BR_PC + INSN_STEP + INSN_STEP)
    `CHK(got.redirect, 1'b1)
    `CHK(got.target, exp_target(16'h8000))
    run_br(ity(OP_SIGN_TEST_GROUP, 5'd2, RT_BRANCH_NEGATIVE_LINK, 16'h8000), lnk, got);
    `CHK(lnk.we, 1'b1)
    `CHK(lnk.addr, LINK_REG)
    `CHK(lnk.data, BR_PC + INSN_STEP + INSN_STEP)
    `CHK(got.redirect, 1'b0)
  endtask

  // Positive branch refuses zero
  task automatic t_branch_positive;
    wb_t lnk;
    pc_ctl_t got;
    run_br(ity(OP_BRANCH_POSITIVE, 5'd5, 5'd0, 16'h0008), lnk, got);
    `CHK(lnk.we, 1'b0)
    `CHK(got.redirect, 1'b0)
    run_br(ity(OP_BRANCH_POSITIVE, 5'd2, 5'd0, 16'h0008), lnk, got);
    `CHK(lnk.we, 1'b0)
    `CHK(got.redirect, 1'b1)
    `CHK(got.target, exp_target(16'h0008))
  endtask

  // Nonpositive branch on zero, negative and positive values
  task automatic t_branch_nonpositive;
    wb_t lnk;
    pc_ctl_t got;
    run_br(ity(OP_BRANCH_NONPOSITIVE, 5'd5, 5'd0, 16'h0003), lnk, got);
    `CHK(lnk.we, 1'b0)
    `CHK(got.redirect, 1'b1)
    `CHK(got.target, exp_target(16'h0003))
    run_br(ity(OP_BRANCH_NONPOSITIVE, 5'd4, 5'd0, 16'h0003), lnk, got);
    `CHK(lnk.we, 1'b0)
    `CHK(got.redirect, 1'b1)
    run_br(ity(OP_BRANCH_NONPOSITIVE, 5'd2, 5'd0, 16'h0003), lnk, got);
    `CHK(lnk.we, 1'b0)
    `CHK(got.redirect, 1'b0)
  endtask

  // Idle cycles between branch and slot; redirect waits for the slot
  task automatic t_branch_gap;
    put(ity(OP_BRANCH_IF_EQUAL, 5'd2, 5'd2, 16'h0004), BR_PC);
    @(posedge mclk_i);
    valid <= 1'b0;
    repeat (2) begin
      @(posedge mclk_i);
      #1;
      `CHK(pcc.redirect, 1'b0)
    end
    put(32'h0000_0000, BR_PC + INSN_STEP);  // Slot holds no branch
    @(posedge mclk_i);
    valid <= 1'b0;
    #1;
    `CHK(pcc.redirect, 1'b1)
    `CHK(pcc.target, exp_target(16'h0004))
  endtask

  task automatic test_done;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the roughly 75 cycles the run needs
  initial begin
    repeat (3000) @(posedge mclk_i);
    n_fail++;
    test_done;
  end

  // ----------------------------------------------------------------
  // Main sequence; register 31 never used as a linking source
  // ----------------------------------------------------------------
  initial begin
    u_rf.regs[1] = 32'h7fff_ffff;
    u_rf.regs[2] = 32'h0000_0001;
    u_rf.regs[3] = 32'hffff_0f0f;
    u_rf.regs[4] = 32'h8000_0000;
    u_rf.regs[5] = 32'h0000_0000;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_add_trapping();
    t_add_wrapping();
    t_add_imm_trapping();
    t_add_imm_wrapping();
    t_conj();
    t_back_to_back();
    t_branch_equal();
    t_branch_nonneg();
    t_branch_nonneg_link();
    t_branch_negative();
    t_branch_negative_link();
    t_branch_positive();
    t_branch_nonpositive();
    t_branch_gap();
    test_done;
  end
endmodule
